/* File: tb/qcp_encoder_model.sv */
/*
 * Behavioural shaft encoder that drives the two phase lines of the block.
 * Assumes the caller steps it from the bench clock domain.
 */
`timescale 1ns/1ps
module qcp_encoder_model (
  input wire logic clk,
  output logic phase_a,
  output logic phase_b
);
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
  end

  // Both lines move on one edge, then hold so that the block surely sees the level.
  task automatic move(input logic a, input logic b);
    @(posedge clk);
    phase_a <= a;
    phase_b <= b;
    repeat (3) @(posedge clk);
  endtask
endmodule

/* File: tb/quadrature_counter_pwm_tb.sv */
/*
 * Self-checking bench of the quadrature counter and PWM block.
 * Assumes the design files and the encoder model are compiled before it.
 */
`timescale 1ns/1ps
`include "qcp_cfg.svh"
module quadrature_counter_pwm_tb;
  logic clk;
  logic rstn;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic enc_a;
  logic enc_b;
  logic pwm_out_pin;
  logic pwm_out_oe;
  logic irq;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] q;
  int h;
  logic [1:0] ab [8] = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b11, 2'b10, 2'b00, 2'b11};
  logic [15:0] cnt [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
                           16'h0004, 16'h0003, 16'h0002, 16'h0001};

  qcp_top dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .count_edge_input(enc_a), .direction_phase_input(enc_b),
    .pwm_out_pin(pwm_out_pin), .pwm_out_oe(pwm_out_oe), .irq(irq));

  qcp_encoder_model enc (.clk(clk), .phase_a(enc_a), .phase_b(enc_b));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      give_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon access; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd_check(input string name, input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    check(name, r, exp);
  endtask

  task automatic high_count(input int n, output int hc);
    hc = 0;
    repeat (n) begin
      @(posedge clk);
      if (pwm_out_pin === 1'b1) hc++;
    end
  endtask

  initial begin
    rstn = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_check("period reset", `QCP_OFS_PERIOD, 32'h0000FFFF);
    rd_check("duty reset", `QCP_OFS_DUTY, 32'h0000FFFF);
    rd_check("mode reset", `QCP_OFS_UNIT_MODE, 32'h00000000);
    rd_check("count reset", `QCP_OFS_COUNT, 32'h00000000);
    check("oe reset", {31'h0, pwm_out_oe}, 32'h0);
    // Mode 3, rising valid edge.
    wr(`QCP_OFS_UNIT_MODE, 32'h81);
    wr(`QCP_OFS_CTRL, 32'h8A);
    enc.move(1'b0, 1'b1);
    enc.move(1'b1, 1'b1);
    rd_check("m3 up", `QCP_OFS_COUNT, 32'h1);
    enc.move(1'b0, 1'b1);
    rd_check("m3 fall ignored", `QCP_OFS_COUNT, 32'h1);
    enc.move(1'b0, 1'b0);
    enc.move(1'b1, 1'b0);
    rd_check("m3 down", `QCP_OFS_COUNT, 32'h0);
    wr(`QCP_OFS_UNIT_MODE, 32'h80);
    enc.move(1'b0, 1'b0);
    rd_check("m3 fall edge", `QCP_OFS_COUNT, 32'hFFFF);
    wr(`QCP_OFS_COUNT, 32'h1234);
    rd_check("count read only", `QCP_OFS_COUNT, 32'hFFFF);
    // Mode 4 with the polarity field set to no edge, which must be disregarded.
    wr(`QCP_OFS_UNIT_MODE, 32'h82);
    wr(`QCP_OFS_CTRL, 32'h8B);
    for (int i = 0; i < 8; i++) begin
      enc.move(ab[i][1], ab[i][0]);
      rd_check("m4 count", `QCP_OFS_COUNT, {16'h0, cnt[i]});
    end
    // PWM set-up done by software in the documented order.
    wr(`QCP_OFS_CTRL, 32'h00);
    wr(`QCP_OFS_PORT0_FUNC, 32'h40);
    wr(`QCP_OFS_UNIT_MODE, 32'hB0);
    repeat (2) @(posedge clk);
    check("oe in updown mode", {31'h0, pwm_out_oe}, 32'h0);
    wr(`QCP_OFS_UNIT_MODE, 32'h30);
    repeat (2) @(posedge clk);
    check("oe in timer mode", {31'h0, pwm_out_oe}, 32'h1);
    wr(`QCP_OFS_PERIOD, 32'h2);
    wr(`QCP_OFS_DUTY, 32'h1);
    wr(`QCP_OFS_IRQ_MASK, 32'h3);
    // Each of the six divisions: one active tick in a three-tick period.
    for (int s = 0; s < 6; s++) begin
      wr(`QCP_OFS_CTRL, 32'hC0 | s);
      repeat (6 * (4 << s)) @(posedge clk);
      high_count(3 * (4 << s), h);
      check("active clocks", h, 4 << s);
    end
    rd_check("both matches", `QCP_OFS_IRQ_STATUS, 32'h3);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(`QCP_OFS_IRQ_MASK, 32'h0);
    @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(`QCP_OFS_IRQ_MASK, 32'h3);
    wr(`QCP_OFS_CTRL, 32'h00);
    wr(`QCP_OFS_IRQ_STATUS, 32'h3);
    @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd_check("status cleared", `QCP_OFS_IRQ_STATUS, 32'h0);
    // Active low output spends the other two ticks high.
    wr(`QCP_OFS_UNIT_MODE, 32'h10);
    wr(`QCP_OFS_CTRL, 32'hC0);
    repeat (24) @(posedge clk);
    high_count(12, h);
    check("active low clocks", h, 8);
    // Equal compares leave the pin inactive.
    wr(`QCP_OFS_UNIT_MODE, 32'h30);
    wr(`QCP_OFS_DUTY, 32'h2);
    repeat (24) @(posedge clk);
    high_count(24, h);
    check("equal compares", h, 0);
    give_verdict();
  end
endmodule

/* File: verilog/qcp_cfg.svh */
/*
 * Register offsets, field positions, reset values and timing figures of the
 * quadrature counter and PWM block.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
`ifndef QCP_CFG_SVH
`define QCP_CFG_SVH

`define QCP_ADDR_W 5
`define QCP_OFS_UNIT_MODE 5'h00
`define QCP_OFS_CTRL 5'h04
`define QCP_OFS_COUNT 5'h08
`define QCP_OFS_PERIOD 5'h0C
`define QCP_OFS_DUTY 5'h10
`define QCP_OFS_IRQ_STATUS 5'h14
`define QCP_OFS_IRQ_MASK 5'h18
`define QCP_OFS_PORT0_FUNC 5'h1C

`define QCP_UM_EDGE_LO 0
`define QCP_UM_EDGE_HI 1
`define QCP_UM_OUT_EN 4
`define QCP_UM_ACT_LVL 5
`define QCP_UM_UPDOWN 7

`define QCP_CC_MODE_LO 0
`define QCP_CC_MODE_HI 1
`define QCP_CC_DIV_HI 2
`define QCP_CC_EXT 3
`define QCP_CC_CLR_EN 6
`define QCP_CC_RUN 7

`define QCP_IRQ_PERIOD 0
`define QCP_IRQ_DUTY 1
`define QCP_P0_BIT6 6

`define QCP_EDGE_FALL 2'h0
`define QCP_EDGE_RISE 2'h1
`define QCP_EDGE_NONE 2'h2
`define QCP_EDGE_BOTH 2'h3

`define QCP_REG_RESET 8'h00
`define QCP_CMP_RESET 16'hFFFF
`define QCP_DIV_BASE 8'h04
`define QCP_DIV_MAX_SEL 3'h5

`endif

/* File: verilog/qcp_edge_detect.sv */
/*
 * Edge detector for a group of inputs synchronous to clk.
 * Assumes the inputs already change only after rising clock edges.
 */
`timescale 1ns/1ps
module qcp_edge_detect #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] sig,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic prev_reg;

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          prev_reg <= 1'b0;
        end else begin
          prev_reg <= sig[i];
        end
      end
      assign rise[i] = sig[i] & ~prev_reg;
      assign fall[i] = ~sig[i] & prev_reg;
    end
  endgenerate
endmodule

/* File: verilog/qcp_pkg.sv */
/*
 * Types shared by the quadrature counter and PWM block.
 * Assumes nothing of its surroundings.
 */
package qcp_pkg;
  typedef enum logic [2:0] {
    QCP_MODE_TIMER,
    QCP_MODE_UPDN_INT,
    QCP_MODE_UPDN_M1,
    QCP_MODE_UPDN_M2,
    QCP_MODE_UPDN_M3,
    QCP_MODE_UPDN_M4
  } qcp_mode_e;
endpackage

/* File: verilog/qcp_prescaler.sv */
/*
 * Count clock prescaler: one-cycle tick every 4 << sel system clocks.
 * Assumes sel above the largest division saturates to the largest one.
 */
`timescale 1ns/1ps
`include "qcp_cfg.svh"
module qcp_prescaler #(
  parameter int DIV_W = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] mask;
  logic [2:0] sel_sat;

  assign sel_sat = (sel > `QCP_DIV_MAX_SEL) ? `QCP_DIV_MAX_SEL : sel;
  assign mask = DIV_W'((`QCP_DIV_BASE << sel_sat) - 8'h01);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
    end else if (!run) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick <= 1'b0;
    end else begin
      tick <= run && ((div_reg & mask) == mask);
    end
  end
endmodule

/* File: verilog/qcp_top.sv */
/*
 * Quadrature up/down counter with cycle-programmable PWM output, with an
 * Avalon-MM register slave and one level interrupt.
 * Assumes encoder inputs synchronous to clk and a 50 MHz system clock.
 */
// Summary of operation
// [R01] Mode 3: sampled low direction counts down.
// [R02] Mode 3: sampled high direction counts up.
// [R03] Mode 4: count every edge of both inputs.
// [R04] Mode 4 ignores the edge polarity field.
// [R05] Simultaneous edges keep the previous direction.
// [R06] PWM pin only in general timer mode.
// [R07] 16-bit period, six internal clock divisions.
// [R08] Software enables port 0 bit 6 function.
// [R09] Software clears updown mode for timer.
// [R10] Output enable and active level select.
// [R11] Software sets compare clear and clock.
// [R12] Count run starts counter and PWM.
// [R13] Period match interrupts, holds, clears next clock.
// [R14] Duty compare sets active duration.
// [R15] Duty match raises its own interrupt.
// [R16] Equal compares keep output inactive.
// [R17] Active on period restart, inactive on duty.
// [R18] Updown mode makes inputs counter pins.
// [R19] Two-bit field selects count edge polarity.
`timescale 1ns/1ps
`include "qcp_cfg.svh"
module qcp_top
  import qcp_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [`QCP_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic count_edge_input,
  input wire logic direction_phase_input,
  output logic pwm_out_pin,
  output logic pwm_out_oe,
  output logic irq
);
  logic [7:0] unit_mode_register;
  logic [7:0] counter_control_register;
  logic [7:0] port0_function_register;
  logic [CNT_W-1:0] period_compare;
  logic [CNT_W-1:0] duty_compare;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic [CNT_W-1:0] updown_counter;
  logic ack_reg;
  logic wr_en;
  logic dir_reg;
  logic match_hold_reg;
  logic counted_reg;
  logic run_d_reg;
  logic restart_d_reg;
  logic pwm_level_reg;
  logic [1:0] in_rise;
  logic [1:0] in_fall;
  logic [1:0] in_edge;
  logic tick;
  logic count_run;
  logic updown_count_mode;
  logic compare_clear_enable;
  logic pwm_output_enable;
  logic pwm_active_level;
  logic port0_bit6_function;
  logic [1:0] edge_polarity_field;
  logic m3_valid_edge;
  logic m4_up;
  logic period_evt;
  logic duty_evt;
  logic start_evt;
  logic restart_evt;
  qcp_mode_e mode;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign updown_count_mode = unit_mode_register[`QCP_UM_UPDOWN];
  assign edge_polarity_field = unit_mode_register[`QCP_UM_EDGE_HI:`QCP_UM_EDGE_LO];
  assign pwm_output_enable = unit_mode_register[`QCP_UM_OUT_EN];
  assign pwm_active_level = unit_mode_register[`QCP_UM_ACT_LVL];
  assign count_run = counter_control_register[`QCP_CC_RUN];
  assign compare_clear_enable = counter_control_register[`QCP_CC_CLR_EN];
  assign port0_bit6_function = port0_function_register[`QCP_P0_BIT6];

  // Register slave: every access is answered one cycle after it is presented.
  assign waitrequest = (read | write) & ~ack_reg;
  assign wr_en = write & ack_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (read | write) & ~ack_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readdata <= '0;
    end else if (read && !ack_reg) begin
      case (address)
        `QCP_OFS_UNIT_MODE: readdata <= {24'h000000, unit_mode_register};
        `QCP_OFS_CTRL: readdata <= {24'h000000, counter_control_register};
        `QCP_OFS_COUNT: readdata <= 32'(updown_counter);
        `QCP_OFS_PERIOD: readdata <= 32'(period_compare);
        `QCP_OFS_DUTY: readdata <= 32'(duty_compare);
        `QCP_OFS_IRQ_STATUS: readdata <= {30'h00000000, irq_status_reg};
        `QCP_OFS_IRQ_MASK: readdata <= {30'h00000000, irq_mask_reg};
        `QCP_OFS_PORT0_FUNC: readdata <= {24'h000000, port0_function_register};
        default: readdata <= '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unit_mode_register <= `QCP_REG_RESET;
      counter_control_register <= `QCP_REG_RESET;
      port0_function_register <= `QCP_REG_RESET;
      period_compare <= CNT_W'(`QCP_CMP_RESET);
      duty_compare <= CNT_W'(`QCP_CMP_RESET);
      irq_mask_reg <= 2'h0;
    end else if (wr_en) begin
      case (address)
        `QCP_OFS_UNIT_MODE: unit_mode_register <= 8'(be_merge(32'(unit_mode_register),
                                                              writedata, byteenable)); // [R10] [R18] [R19]
        `QCP_OFS_CTRL: counter_control_register <= 8'(be_merge(32'(counter_control_register),
                                                              writedata, byteenable));
        `QCP_OFS_PERIOD: period_compare <= CNT_W'(be_merge(32'(period_compare), writedata,
                                                           byteenable));
        `QCP_OFS_DUTY: duty_compare <= CNT_W'(be_merge(32'(duty_compare), writedata,
                                                       byteenable)); // [R14]
        `QCP_OFS_IRQ_MASK: irq_mask_reg <= 2'(be_merge(32'(irq_mask_reg), writedata,
                                                       byteenable));
        `QCP_OFS_PORT0_FUNC: port0_function_register <= 8'(be_merge(
                                 32'(port0_function_register), writedata, byteenable));
        default: ;
      endcase
    end
  end

  always_comb begin
    if (!updown_count_mode) begin
      mode = QCP_MODE_TIMER;
    end else if (!counter_control_register[`QCP_CC_EXT]) begin
      mode = QCP_MODE_UPDN_INT;
    end else begin
      case (counter_control_register[`QCP_CC_MODE_HI:`QCP_CC_MODE_LO])
        2'h0: mode = QCP_MODE_UPDN_M1;
        2'h1: mode = QCP_MODE_UPDN_M2;
        2'h2: mode = QCP_MODE_UPDN_M3;
        default: mode = QCP_MODE_UPDN_M4;
      endcase
    end
  end

  qcp_prescaler #(
    .DIV_W(8)
  ) u_prescaler (
    .clk(clk),
    .rstn(rstn),
    .run(count_run),
    .sel({counter_control_register[`QCP_CC_DIV_HI],
          counter_control_register[`QCP_CC_MODE_HI:`QCP_CC_MODE_LO]}), // [R07]
    .tick(tick)
  );

  qcp_edge_detect #(
    .WIDTH(2)
  ) u_edges (
    .clk(clk),
    .rstn(rstn),
    .sig({direction_phase_input, count_edge_input}),
    .rise(in_rise),
    .fall(in_fall)
  );

  assign in_edge = in_rise | in_fall;

  always_comb begin
    case (edge_polarity_field) // [R19]
      `QCP_EDGE_FALL: m3_valid_edge = in_fall[0];
      `QCP_EDGE_RISE: m3_valid_edge = in_rise[0];
      `QCP_EDGE_BOTH: m3_valid_edge = in_edge[0];
      default: m3_valid_edge = 1'b0;
    endcase
  end

  // Quadrature direction: the count edge input leading the direction phase input counts up.
  always_comb begin
    if (in_edge[0]) begin
      m4_up = count_edge_input != direction_phase_input;
    end else begin
      m4_up = direction_phase_input == count_edge_input;
    end
  end

  assign start_evt = count_run & ~run_d_reg;
  assign restart_evt = (mode == QCP_MODE_TIMER) && count_run && tick && match_hold_reg;
  assign period_evt = (mode == QCP_MODE_TIMER) && counted_reg &&
                      (updown_counter == period_compare);
  assign duty_evt = (mode == QCP_MODE_TIMER) && counted_reg &&
                    (updown_counter == duty_compare);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_d_reg <= 1'b0;
      counted_reg <= 1'b0;
      restart_d_reg <= 1'b0;
    end else begin
      run_d_reg <= count_run;
      // The set lags the clearing tick by one cycle, as the compares do, so spans are exact.
      restart_d_reg <= restart_evt;
      counted_reg <= (mode == QCP_MODE_TIMER) && count_run && tick;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      updown_counter <= '0;
      dir_reg <= 1'b1;
    end else if (count_run) begin // [R12]
      case (mode)
        QCP_MODE_TIMER: begin
          if (tick) begin
            if (match_hold_reg) begin
              updown_counter <= '0; // [R13]
            end else begin
              updown_counter <= updown_counter + CNT_W'(1);
            end
          end
        end
        QCP_MODE_UPDN_M3: begin
          if (m3_valid_edge) begin
            if (direction_phase_input) begin
              updown_counter <= updown_counter + CNT_W'(1); // [R02]
            end else begin
              updown_counter <= updown_counter - CNT_W'(1); // [R01]
            end
          end
        end
        QCP_MODE_UPDN_M4: begin
          if (&in_edge) begin
            if (dir_reg) begin
              updown_counter <= updown_counter + CNT_W'(1); // [R05]
            end else begin
              updown_counter <= updown_counter - CNT_W'(1); // [R05]
            end
          end else if (|in_edge) begin
            dir_reg <= m4_up;
            if (m4_up) begin
              updown_counter <= updown_counter + CNT_W'(1); // [R03] [R04]
            end else begin
              updown_counter <= updown_counter - CNT_W'(1); // [R03] [R04]
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      match_hold_reg <= 1'b0;
    end else if (restart_evt || mode != QCP_MODE_TIMER) begin
      match_hold_reg <= 1'b0;
    end else if (period_evt && compare_clear_enable) begin
      match_hold_reg <= 1'b1; // [R13]
    end
  end

  // A clearing duty match or equal compares outrank a set, so equal compares stay inactive.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_level_reg <= 1'b0;
    end else if (!count_run || mode != QCP_MODE_TIMER) begin
      pwm_level_reg <= 1'b0;
    end else if (duty_evt || period_compare == duty_compare) begin
      pwm_level_reg <= 1'b0; // [R16] [R17]
    end else if (restart_d_reg || start_evt) begin
      pwm_level_reg <= 1'b1; // [R17] [R12]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwm_out_pin <= 1'b0;
      pwm_out_oe <= 1'b0;
    end else begin
      pwm_out_pin <= pwm_active_level ? pwm_level_reg : ~pwm_level_reg; // [R10]
      pwm_out_oe <= port0_bit6_function && pwm_output_enable &&
                    (mode == QCP_MODE_TIMER); // [R06] [R10]
    end
  end

  // Sticky status: a new event in the clearing cycle wins over the clear.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_status_reg <= 2'h0;
    end else begin
      irq_status_reg <= (irq_status_reg &
                         ~((wr_en && address == `QCP_OFS_IRQ_STATUS && byteenable[0]) ?
                           writedata[1:0] : 2'h0)) |
                        {duty_evt, period_evt}; // [R13] [R15]
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  chk_m3_down_count: assert property ((mode == QCP_MODE_UPDN_M3) && count_run && m3_valid_edge &&
      !direction_phase_input |=> updown_counter == $past(updown_counter) - CNT_W'(1)) // [R01]
    else $error("mode 3 low direction did not count down");
  chk_m3_up_count: assert property ((mode == QCP_MODE_UPDN_M3) && count_run && m3_valid_edge &&
      direction_phase_input |=> updown_counter == $past(updown_counter) + CNT_W'(1)) // [R02]
    else $error("mode 3 high direction did not count up");
  chk_m4_single_edge: assert property ((mode == QCP_MODE_UPDN_M4) && count_run &&
      (in_edge == 2'h2) |=> updown_counter != $past(updown_counter)) // [R03]
    else $error("mode 4 phase edge not counted");
  chk_m4_any_polarity: assert property ((mode == QCP_MODE_UPDN_M4) && count_run &&
      in_fall[0] && !in_edge[1] && (edge_polarity_field == `QCP_EDGE_RISE)
      |=> updown_counter != $past(updown_counter)) // [R04]
    else $error("mode 4 honoured edge polarity");
  chk_m4_keep_dir: assert property ((mode == QCP_MODE_UPDN_M4) && count_run && (&in_edge)
      |=> updown_counter == ($past(dir_reg) ? $past(updown_counter) + CNT_W'(1) :
                             $past(updown_counter) - CNT_W'(1))) // [R05]
    else $error("mode 4 simultaneous edges changed direction");
  chk_pwm_oe_mode: assert property (pwm_out_oe |-> $past(mode) == QCP_MODE_TIMER) // [R06]
    else $error("PWM pin driven outside timer mode");
  chk_period_clear: assert property (restart_evt |=> updown_counter == '0) // [R13]
    else $error("counter not cleared after period match");
  chk_period_irq: assert property (period_evt |=> irq_status_reg[`QCP_IRQ_PERIOD]) // [R13]
    else $error("period match not flagged");
  chk_duty_irq: assert property (duty_evt |=> irq_status_reg[`QCP_IRQ_DUTY] ##1
      !pwm_out_pin == $past(pwm_active_level)) // [R15]
    else $error("duty match not flagged or output not inactive");
  chk_equal_inactive: assert property (count_run && (period_compare == duty_compare)
      |=> !pwm_level_reg) // [R16]
    else $error("equal compares drove active level");
  chk_restart_active: assert property (restart_evt ##1 (count_run && (mode == QCP_MODE_TIMER) &&
      (period_compare != duty_compare) && !duty_evt) |=> pwm_level_reg) // [R17]
    else $error("PWM not active at period restart");

  cov_m4_both_edges: cover property ((mode == QCP_MODE_UPDN_M4) && count_run && (&in_edge));
  cov_pwm_period: cover property (restart_evt ##[1:300] duty_evt);
  cov_irq_raised: cover property (!irq ##1 irq);
endmodule
